/* src/kcpm_addr_match.sv */
// request filter of one slave port
module kcpm_addr_match
  import kcpm_pkg::*;
(
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  // configured address
  input  wire logic [ADDR_W-1:0] cfg_addr,
  // decoded request
  input  wire logic              req_valid,
  input  wire logic [ADDR_W-1:0] req_addr,
  // answer permission
  output logic                   resp_en
);

  logic resp_q;

  // a foreign address leaves the port silent
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      resp_q <= 1'b0;
    end else begin
      resp_q <= req_valid && (req_addr == cfg_addr);
    end
  end

  assign resp_en = resp_q;

endmodule

/* src/kcpm_key_sync.sv */
// one keypad pin: three flops, a change counts once stages two and three agree
module kcpm_key_sync (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // raw pin
  input  wire logic key_pin,
  // filtered key
  output logic      key_level,
  output logic      key_press
);

  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic level_q;
  logic press_q;

  // synchroniser chain; s1 feeds only s2
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= key_pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // a one-cycle glitch never makes stages two and three agree on a new value
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      level_q <= 1'b0;
      press_q <= 1'b0;
    end else begin
      press_q <= 1'b0;
      if (s2_q == s3_q) begin
        level_q <= s3_q;
        press_q <= s3_q & ~level_q;
      end
    end
  end

  assign key_level = level_q;
  assign key_press = press_q;

endmodule

/* src/kcpm_menu.sv */
// Summary of operation
// - two slave ports, own address and baud each
// - addresses from 1 to 65535 accepted
// - 252 to 255 and 64764 never assignable
// - port answers only its own address
// - reset address of each port is 1
// - baud 300 to 38400, chosen per port
// - reset baud of each port is 9600
// - menu opens on up and enter together
// - first item port one address, rightmost digit
// - up bumps digit, left moves selection left
// - enter stores address, goes to same baud
// - up steps to next baud value
// - second enter reaches port two address
// - third enter port two baud, then date prompt
module kcpm_menu
  import kcpm_pkg::*;
#(
  parameter int NDIG = NUM_DIGITS
) (
  // clock and reset
  input  wire logic                          clk,
  input  wire logic                          rst_n,
  // apb slave
  input  wire logic [7:0]                    paddr,
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [31:0]                   pwdata,
  output logic                               pready,
  output logic [31:0]                        prdata,
  output logic                               pslverr,
  // keypad pins, high while pressed
  input  wire logic                          key_up,
  input  wire logic                          key_left,
  input  wire logic                          key_enter,
  // decoded modbus requests per port
  input  wire logic [1:0]                    req_valid,
  input  wire logic [1:0][kcpm_pkg::ADDR_W-1:0] req_addr,
  // port configuration and answer permission
  output logic [1:0]                         resp_en,
  output logic [1:0][kcpm_pkg::ADDR_W-1:0]   slave_addr,
  output logic [1:0][kcpm_pkg::BAUD_W-1:0]   baud_sel,
  output logic [1:0][kcpm_pkg::DIV_W-1:0]    baud_div,
  // display side
  output kcpm_pkg::kcpm_state_t              menu_item,
  output logic [2:0]                         digit_sel,
  output logic [4*kcpm_pkg::NUM_DIGITS-1:0]  edit_digits,
  output logic                               date_prompt
);

  import kcpm_pkg::*;

  // the editor must hold 65535 and the digit pointer is three bits
  if (NDIG != NUM_DIGITS) begin : g_bad_ndig
    $error("kcpm_menu: NDIG must equal NUM_DIGITS");
  end

  // the slowest rate needs the widest bit timer divisor
  if ((CLK_HZ / BAUD_RATE[BAUD_FIRST]) >= (1 << DIV_W)) begin : g_bad_div
    $error("kcpm_menu: DIV_W too narrow for the slowest baud rate");
  end

  // address stores and the decimal editor keep exactly sixteen address bits
  if (ADDR_W != 16) begin : g_bad_addr_w
    $error("kcpm_menu: ADDR_W must be 16");
  end

  // divisor after reset as a plain constant, so the reset branch loads no logic
  localparam logic [DIV_W-1:0] DIV_RST = kcpm_baud_div(BAUD_RST);

  logic [NUM_KEYS-1:0]             key_pin;
  logic [NUM_KEYS-1:0]             key_lvl;
  logic [NUM_KEYS-1:0]             key_prs;
  kcpm_state_t                     state_q;
  kcpm_state_t                     state_d;
  logic                            armed_q;
  logic [2:0]                      sel_q;
  logic [NDIG-1:0][DIGIT_W-1:0]    dig_q;
  logic [2:0]                      baud_edit_q;
  logic [1:0][ADDR_W-1:0]          addr_q;
  logic [1:0][BAUD_W-1:0]          baud_q;
  logic [1:0][DIV_W-1:0]           div_q;
  logic [16:0]                     edit_val;
  logic                            edit_ok;
  logic                            up_p;
  logic                            left_p;
  logic                            ent_p;
  logic                            combo;
  logic                            apb_acc;
  logic                            apb_wr;
  logic                            pready_q;
  logic                            pslverr_q;
  logic [31:0]                     prdata_q;
  logic [31:0]                     rd_mux;
  logic                            rd_hit;
  logic                            key_store;
  logic                            bus_addr_ok;

  assign key_pin = {key_enter, key_left, key_up};

  // every key pin crosses into the clock domain on its own
  for (genvar k = 0; k < NUM_KEYS; k++) begin : g_key
    kcpm_key_sync u_sync (
      .clk       (clk),
      .rst_n     (rst_n),
      .key_pin   (key_pin[k]),
      .key_level (key_lvl[k]),
      .key_press (key_prs[k])
    );
  end

  // one request filter per slave port
  for (genvar p = 0; p < 2; p++) begin : g_port
    kcpm_addr_match u_match (
      .clk       (clk),
      .rst_n     (rst_n),
      .cfg_addr  (addr_q[p]),
      .req_valid (req_valid[p]),
      .req_addr  (req_addr[p]),
      .resp_en   (resp_en[p])
    );
  end

  // presses count only once all keys were let go after the opening chord
  assign combo  = key_lvl[KEY_UP] & key_lvl[KEY_ENTER];
  assign up_p   = armed_q & key_prs[KEY_UP];
  assign left_p = armed_q & key_prs[KEY_LEFT];
  assign ent_p  = armed_q & key_prs[KEY_ENTER];

  // decimal digits to binary; 17 bits so 99999 is seen as out of range
  always_comb begin
    edit_val = 17'h00000;
    for (int i = NDIG - 1; i >= 0; i--) begin
      edit_val = 17'((edit_val * 17'd10) + {13'h0000, dig_q[i]});
    end
    edit_ok = kcpm_addr_ok(edit_val);
  end

  // menu sequence: port one address, baud, port two address, baud, date prompt
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (combo) begin
          state_d = ST_ADDR1;
        end
      end
      ST_ADDR1: begin
        if (ent_p) begin
          state_d = ST_BAUD1;
        end
      end
      ST_BAUD1: begin
        if (ent_p) begin
          state_d = ST_ADDR2;
        end
      end
      ST_ADDR2: begin
        if (ent_p) begin
          state_d = ST_BAUD2;
        end
      end
      ST_BAUD2: begin
        if (ent_p) begin
          state_d = ST_DTIME;
        end
      end
      ST_DTIME: begin
        // date editing lives elsewhere; enter here closes this menu
        if (ent_p) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // disarm on menu entry so the chord's own enter is not taken as a step
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      armed_q <= 1'b0;
    end else if (state_q == ST_IDLE) begin
      armed_q <= 1'b0;
    end else if (key_lvl == '0) begin
      armed_q <= 1'b1;
    end
  end

  // address editor: starts blank with the rightmost digit selected
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sel_q <= 3'h0;
      dig_q <= '0;
    end else if (state_d != state_q) begin
      sel_q <= 3'h0;
      dig_q <= '0;
    end else if ((state_q == ST_ADDR1) || (state_q == ST_ADDR2)) begin
      if (up_p) begin
        // digits roll 9 to 0 so any value is reachable by up alone
        dig_q[sel_q] <= (dig_q[sel_q] == DIGIT_MAX) ? 4'h0 : dig_q[sel_q] + 4'h1;
      end else if (left_p) begin
        // past the leftmost digit the selection returns to the right end
        sel_q <= (sel_q == 3'(NDIG - 1)) ? 3'h0 : sel_q + 3'h1;
      end
    end
  end

  // baud editor: loads the stored value, steps and wraps on up
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      baud_edit_q <= BAUD_RST;
    end else if (state_d == ST_BAUD1 && state_q != ST_BAUD1) begin
      baud_edit_q <= baud_q[0];
    end else if (state_d == ST_BAUD2 && state_q != ST_BAUD2) begin
      baud_edit_q <= baud_q[1];
    end else if (up_p && (state_q == ST_BAUD1 || state_q == ST_BAUD2)) begin
      baud_edit_q <= (baud_edit_q == BAUD_LAST) ? BAUD_FIRST : baud_edit_q + 3'h1;
    end
  end

  // apb decode; pready comes from a flop so every access takes one wait state
  assign apb_acc = psel & penable & pready_q;
  assign apb_wr  = apb_acc & pwrite & rd_hit;

  // an enter on an address or baud item blocks bus writes to the settings in that cycle
  assign key_store   = ent_p & (state_q inside {ST_ADDR1, ST_BAUD1, ST_ADDR2, ST_BAUD2});
  assign bus_addr_ok = kcpm_addr_ok({1'b0, pwdata[15:0]});

  // stored addresses; a keypad store wins over a bus write in the same cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      addr_q <= {ADDR_RST, ADDR_RST};
    end else if (key_store) begin
      if (state_q == ST_ADDR1 && edit_ok) begin
        addr_q[0] <= edit_val[15:0];
      end
      if (state_q == ST_ADDR2 && edit_ok) begin
        addr_q[1] <= edit_val[15:0];
      end
    end else if (apb_wr) begin
      case (paddr)
        OFF_ADDR1: begin
          if (bus_addr_ok) begin
            addr_q[0] <= pwdata[15:0];
          end
        end
        OFF_ADDR2: begin
          if (bus_addr_ok) begin
            addr_q[1] <= pwdata[15:0];
          end
        end
        default: begin
        end
      endcase
    end
  end

  // stored baud indices; a bus write takes only the index bits
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      baud_q <= {BAUD_RST, BAUD_RST};
    end else if (key_store) begin
      if (state_q == ST_BAUD1) begin
        baud_q[0] <= baud_edit_q;
      end
      if (state_q == ST_BAUD2) begin
        baud_q[1] <= baud_edit_q;
      end
    end else if (apb_wr) begin
      case (paddr)
        OFF_BAUD1: begin
          baud_q[0] <= pwdata[BAUD_W-1:0];
        end
        OFF_BAUD2: begin
          baud_q[1] <= pwdata[BAUD_W-1:0];
        end
        default: begin
        end
      endcase
    end
  end

  // bit timer divisors follow the stored baud; the master must match it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_q <= {DIV_RST, DIV_RST};
    end else begin
      div_q[0] <= kcpm_baud_div(baud_q[0]);
      div_q[1] <= kcpm_baud_div(baud_q[1]);
    end
  end

  // read mux; status and editor are read only
  always_comb begin
    rd_mux = 32'h0000_0000;
    rd_hit = 1'b1;
    case (paddr)
      OFF_ADDR1:  rd_mux = {16'h0000, addr_q[0]};
      OFF_BAUD1:  rd_mux = {29'h0000_0000, baud_q[0]};
      OFF_ADDR2:  rd_mux = {16'h0000, addr_q[1]};
      OFF_BAUD2:  rd_mux = {29'h0000_0000, baud_q[1]};
      OFF_STATUS: rd_mux = {19'h0_0000, armed_q, sel_q, baud_edit_q, state_q};
      OFF_EDIT:   rd_mux = {12'h000, dig_q};
      default:    rd_hit = 1'b0;
    endcase
  end

  // apb answer: pready high in the second access cycle, errors on unmapped
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else begin
      pready_q  <= psel & penable & ~pready_q;
      pslverr_q <= psel & penable & ~pready_q & ~rd_hit;
      prdata_q  <= (psel & penable & ~pready_q & ~pwrite) ? rd_mux : 32'h0000_0000;
    end
  end

  assign pready      = pready_q;
  assign pslverr     = pslverr_q;
  assign prdata      = prdata_q;
  assign slave_addr  = addr_q;
  assign baud_sel    = baud_q;
  assign baud_div    = div_q;
  assign menu_item   = state_q;
  assign digit_sel   = sel_q;
  assign edit_digits = dig_q;
  assign date_prompt = state_q[5];

endmodule

/* src/kcpm_pkg.sv */
package kcpm_pkg;

  // address field and the values the ports may not take
  localparam int             ADDR_W      = 16;
  localparam logic [15:0]    ADDR_NONE   = 16'h0000;
  localparam logic [15:0]    ADDR_RSV_LO = 16'h00fc;  // 252
  localparam logic [15:0]    ADDR_RSV_HI = 16'h00ff;  // 255
  localparam logic [15:0]    ADDR_RSV_X  = 16'hfcfc;  // 64764
  localparam logic [15:0]    ADDR_RST    = 16'h0001;

  // baud index table, 300 up to 38400
  localparam int             BAUD_W      = 3;
  localparam logic [2:0]     BAUD_RST    = 3'h5;      // 9600
  localparam logic [2:0]     BAUD_FIRST  = 3'h0;      // 300
  localparam logic [2:0]     BAUD_LAST   = 3'h7;      // 38400
  localparam int             BAUD_RATE [8] = '{300, 600, 1200, 2400, 4800, 9600, 19200, 38400};
  localparam int             CLK_HZ      = 100_000_000;
  localparam int             DIV_W       = 20;

  // decimal digits in the address editor
  localparam int             NUM_DIGITS  = 5;
  localparam int             DIGIT_W     = 4;
  localparam logic [3:0]     DIGIT_MAX   = 4'h9;

  // apb register byte offsets
  localparam logic [7:0]     OFF_ADDR1   = 8'h00;
  localparam logic [7:0]     OFF_BAUD1   = 8'h04;
  localparam logic [7:0]     OFF_ADDR2   = 8'h08;
  localparam logic [7:0]     OFF_BAUD2   = 8'h0c;
  localparam logic [7:0]     OFF_STATUS  = 8'h10;
  localparam logic [7:0]     OFF_EDIT    = 8'h14;

  // key positions in the key vector
  localparam int             KEY_UP      = 0;
  localparam int             KEY_LEFT    = 1;
  localparam int             KEY_ENTER   = 2;
  localparam int             NUM_KEYS    = 3;

  // menu items, one-hot
  typedef enum logic [5:0] {
    ST_IDLE  = 6'b000001,
    ST_ADDR1 = 6'b000010,
    ST_BAUD1 = 6'b000100,
    ST_ADDR2 = 6'b001000,
    ST_BAUD2 = 6'b010000,
    ST_DTIME = 6'b100000
  } kcpm_state_t;

  // clocks per bit for a baud index
  function automatic logic [DIV_W-1:0] kcpm_baud_div(input logic [2:0] idx);
    kcpm_baud_div = DIV_W'(CLK_HZ / BAUD_RATE[idx]);
  endfunction

  // zero and reserved values are never assignable
  function automatic logic kcpm_addr_ok(input logic [16:0] a);
    kcpm_addr_ok = (a != 17'h00000) && (a[16] == 1'b0)
                && !(a[15:0] >= ADDR_RSV_LO && a[15:0] <= ADDR_RSV_HI)
                && (a[15:0] != ADDR_RSV_X);
  endfunction

endpackage

/* verification/kcpm_far_model.sv */
// operator at the keypad and modbus master behind the request decoder
module kcpm_far_model
  import kcpm_pkg::*;
(
  // clock
  input  wire logic              clk,
  // keypad pins
  output logic                   key_up,
  output logic                   key_left,
  output logic                   key_enter,
  // master requests and answers
  output logic [1:0]             req_valid,
  output logic [1:0][ADDR_W-1:0] req_addr,
  input  wire logic [1:0]        resp_en
);
  timeunit 1ns;
  timeprecision 1ps;

  // idle pins, no request
  initial begin
    key_up = 1'b0;
    key_left = 1'b0;
    key_enter = 1'b0;
    req_valid = 2'h0;
    req_addr = '0;
  end

  // press and release each held 8 cycles, well past the 3-flop filter
  task automatic press(input logic u, input logic l, input logic e);
    @(posedge clk);
    key_up <= u;
    key_left <= l;
    key_enter <= e;
    repeat (8) @(posedge clk);
    key_up <= 1'b0;
    key_left <= 1'b0;
    key_enter <= 1'b0;
    repeat (8) @(posedge clk);
  endtask

  // one-cycle request; answer permission sampled two edges later
  task automatic poll(input int p, input logic [ADDR_W-1:0] a, output logic hit);
    @(posedge clk);
    req_valid[p] <= 1'b1;
    req_addr[p] <= a;
    @(posedge clk);
    req_valid[p] <= 1'b0;
    req_addr[p] <= ~a;  // released: inverse, never the stale value
    @(posedge clk);
    hit = resp_en[p];
  endtask
endmodule

/* verification/kcpm_menu_asserts.sv */
// watches the menu block from its ports only
module kcpm_menu_asserts
  import kcpm_pkg::*;
(
  // clock and reset
  input wire logic                    clk,
  input wire logic                    rst_n,
  // apb strobes
  input wire logic                    psel,
  input wire logic                    penable,
  input wire logic                    pwrite,
  // request filter
  input wire logic [1:0]              req_valid,
  input wire logic [1:0][ADDR_W-1:0]  req_addr,
  input wire logic [1:0]              resp_en,
  // stored settings and menu
  input wire logic [1:0][ADDR_W-1:0]  slave_addr,
  input wire logic [1:0][BAUD_W-1:0]  baud_sel,
  input wire logic [1:0][DIV_W-1:0]   baud_div,
  input wire kcpm_state_t             menu_item,
  input wire logic [2:0]              digit_sel,
  input wire logic [4*NUM_DIGITS-1:0] edit_digits,
  input wire logic                    date_prompt
);
  timeunit 1ns;
  timeprecision 1ps;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // helpers: apb write strobe, forbidden stored addresses
  logic       apb_wr;
  logic [1:0] bad;
  assign apb_wr = psel && penable && pwrite;
  assign bad[0] = slave_addr[0] inside {16'h0000, [ADDR_RSV_LO:ADDR_RSV_HI], ADDR_RSV_X};
  assign bad[1] = slave_addr[1] inside {16'h0000, [ADDR_RSV_LO:ADDR_RSV_HI], ADDR_RSV_X};

  a_resp_match: assert property (req_valid[0] && req_addr[0] == slave_addr[0] |=> resp_en[0])
    else $error("port 0 missed its own address");
  a_resp_silent: assert property (!(req_valid[0] && req_addr[0] == slave_addr[0]) |=> !resp_en[0])
    else $error("port 0 answered a foreign address");
  a_resp_port2: assert property (resp_en[1] == ($past(req_valid[1]) && $past(req_addr[1]) == $past(slave_addr[1])))
    else $error("port 1 answer wrong");
  a_addr_legal: assert property (bad == 2'h0)
    else $error("stored address is zero or reserved");
  a_div_follow: assert property (baud_div[0] == DIV_W'(CLK_HZ / BAUD_RATE[$past(baud_sel[0])]))
    else $error("bit divider does not match baud index");
  a_open_addr1: assert property (menu_item == ST_IDLE ##1 menu_item != ST_IDLE |-> menu_item == ST_ADDR1)
    else $error("menu opened on a wrong item");
  a_entry_clear: assert property ($changed(menu_item) && menu_item inside {ST_ADDR1, ST_ADDR2} |-> digit_sel == 3'h0 && edit_digits == '0)
    else $error("address item not starting at rightmost digit");
  a_item_order: assert property ($changed(menu_item) |-> menu_item == ($past(menu_item) << 1) || (menu_item == ST_IDLE && $past(menu_item) == ST_DTIME))
    else $error("menu items out of order");
  a_prompt_flag: assert property (date_prompt == (menu_item == ST_DTIME))
    else $error("date prompt flag wrong");
  a_baud_hold: assert property ($changed(baud_sel[0]) |-> $past(menu_item) == ST_BAUD1 || $past(apb_wr))
    else $error("port 0 baud changed without cause");

  // main scenarios reached
  c_prompt: cover property (date_prompt);
  c_resp0: cover property (resp_en[0]);
  c_resp1: cover property (resp_en[1]);
endmodule

bind kcpm_menu kcpm_menu_asserts u_chk (.clk, .rst_n, .psel, .penable, .pwrite, .req_valid,
  .req_addr, .resp_en, .slave_addr, .baud_sel, .baud_div, .menu_item, .digit_sel,
  .edit_digits, .date_prompt);

/* verification/keypad_comm_parameter_menu_test.sv */
module keypad_comm_parameter_menu_test;
  timeunit 1ns;
  timeprecision 1ps;
  import kcpm_pkg::*;

  logic                   clk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic [7:0]             paddr;
  logic [31:0]            pwdata, prdata;
  logic                   key_up, key_left, key_enter, date_prompt;
  logic [1:0]             req_valid, resp_en;
  logic [1:0][ADDR_W-1:0] req_addr, slave_addr;
  logic [1:0][BAUD_W-1:0] baud_sel;
  logic [1:0][DIV_W-1:0]  baud_div;
  kcpm_state_t            menu_item;
  logic [2:0]             digit_sel;
  logic [19:0]            edit_digits;
  int                     n_errors, samples_checked;

  kcpm_menu #(.NDIG(NUM_DIGITS)) dut (
    .clk(clk), .rst_n(rst_n), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .key_up(key_up), .key_left(key_left), .key_enter(key_enter),
    .req_valid(req_valid), .req_addr(req_addr), .resp_en(resp_en),
    .slave_addr(slave_addr), .baud_sel(baud_sel), .baud_div(baud_div),
    .menu_item(menu_item), .digit_sel(digit_sel), .edit_digits(edit_digits),
    .date_prompt(date_prompt)
  );
  kcpm_far_model far (
    .clk(clk), .key_up(key_up), .key_left(key_left), .key_enter(key_enter),
    .req_valid(req_valid), .req_addr(req_addr), .resp_en(resp_en)
  );

  // 100 MHz
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic tally_and_finish();
    if (n_errors == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  // one apb transfer; request held until pready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int i;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (i == 16) begin
      n_errors++;
      tally_and_finish();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input logic e_exp);
    logic [31:0] q;
    logic        e;
    apb(1'b0, a, 32'h0, q, e);
    chk("prdata", exp, q);
    chk("pslverr", {31'h0, e_exp}, {31'h0, e});
  endtask

  task automatic t_reset();
    rdchk(OFF_ADDR1, 32'h1, 1'b0);
    rdchk(OFF_BAUD1, 32'h5, 1'b0);
    rdchk(OFF_ADDR2, 32'h1, 1'b0);
    rdchk(OFF_BAUD2, 32'h5, 1'b0);
    chk("baud_div1", 32'd10416, 32'(baud_div[1]));
    rdchk(OFF_STATUS, 32'h141, 1'b0);
    rdchk(OFF_EDIT, 32'h0, 1'b0);
    rdchk(8'h20, 32'h0, 1'b1);
  endtask

  task automatic t_match();
    logic hit;
    far.poll(0, 16'h0001, hit);
    chk("resp_en0", 32'h1, {31'h0, hit});
    far.poll(0, 16'h0002, hit);
    chk("resp_en0", 32'h0, {31'h0, hit});
    far.poll(1, 16'h0001, hit);
    chk("resp_en1", 32'h1, {31'h0, hit});
  endtask

  // walk the whole menu: entry, digit edit, baud wrap, zero entry, prompt
  task automatic t_menu();
    logic hit;
    far.press(1'b1, 1'b0, 1'b0);
    chk("menu_item", ST_IDLE, menu_item);
    far.press(1'b1, 1'b0, 1'b1);
    chk("menu_item", ST_ADDR1, menu_item);
    chk("digit_sel", 32'h0, digit_sel);
    far.press(1'b1, 1'b0, 1'b0);
    far.press(1'b0, 1'b1, 1'b0);
    chk("digit_sel", 32'h1, digit_sel);
    far.press(1'b1, 1'b0, 1'b0);
    far.press(1'b1, 1'b0, 1'b0);
    chk("edit_digits", 32'h21, edit_digits);
    far.press(1'b0, 1'b0, 1'b1);
    chk("slave_addr0", 32'd21, slave_addr[0]);
    chk("menu_item", ST_BAUD1, menu_item);
    repeat (3) far.press(1'b1, 1'b0, 1'b0);
    far.press(1'b0, 1'b0, 1'b1);
    chk("baud_sel0", 3'(BAUD_RST + 3'h3), baud_sel[0]);
    chk("baud_sel1", BAUD_RST, baud_sel[1]);
    chk("baud_div0", CLK_HZ / BAUD_RATE[0], baud_div[0]);
    chk("menu_item", ST_ADDR2, menu_item);
    chk("digit_sel", 32'h0, digit_sel);
    far.press(1'b0, 1'b0, 1'b1);
    chk("slave_addr1", 32'h1, slave_addr[1]);
    chk("menu_item", ST_BAUD2, menu_item);
    far.press(1'b1, 1'b0, 1'b0);
    far.press(1'b0, 1'b0, 1'b1);
    chk("baud_sel1", 32'h6, baud_sel[1]);
    chk("date_prompt", 32'h1, date_prompt);
    far.press(1'b0, 1'b0, 1'b1);
    chk("menu_item", ST_IDLE, menu_item);
    far.poll(0, 16'd21, hit);
    chk("resp_en0", 32'h1, {31'h0, hit});
  endtask

  task automatic t_apb();
    logic hit;
    wr(OFF_ADDR2, {16'h0, ADDR_RSV_X});
    rdchk(OFF_ADDR2, 32'h1, 1'b0);
    wr(OFF_ADDR2, {16'h0, ADDR_RSV_LO});
    rdchk(OFF_ADDR2, 32'h1, 1'b0);
    wr(OFF_ADDR2, {16'h0, ADDR_RSV_HI});
    rdchk(OFF_ADDR2, 32'h1, 1'b0);
    wr(OFF_ADDR2, 32'hffff);
    rdchk(OFF_ADDR2, 32'hffff, 1'b0);
    far.poll(1, 16'hffff, hit);
    chk("resp_en1", 32'h1, {31'h0, hit});
    far.poll(0, 16'hffff, hit);
    chk("resp_en0", 32'h0, {31'h0, hit});
    wr(OFF_BAUD2, {29'h0, BAUD_LAST});
    rdchk(OFF_BAUD2, {29'h0, BAUD_LAST}, 1'b0);
    // second reset in mid-run restores the factory address
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk("slave_addr1", 32'h1, slave_addr[1]);
    chk("baud_sel1", BAUD_RST, baud_sel[1]);
    chk("menu_item", ST_IDLE, menu_item);
  endtask

  initial begin
    n_errors = 0;
    samples_checked = 0;
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_match();
    t_menu();
    t_apb();
    tally_and_finish();
  end
endmodule
